// >>> tb/gatl_ext_model.sv
// external equipment on the trigger and alarm pins
`timescale 1ns/1ps
module gatl_ext_model (
    input  wire logic alarm_output_i,
    input  wire logic alarm_output_oe_i,
    output wire logic trigger_input_o,
    output wire logic alarm_pin_o
);
    logic pull_low;
    ////////////////////////////////////////////////////////////
    // pin rests high on its pull-up unless this side sinks it
    assign trigger_input_o = pull_low ? 1'b0 : 1'b1;
    // open collector: a released pin floats up on the weak pull-up, never holds old data
    assign alarm_pin_o = alarm_output_oe_i ? alarm_output_i : 1'b1;
    initial pull_low = 1'b0;
    task automatic drive(input logic low);
        pull_low = low;
    endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the trigger and alarm block
`timescale 1ns/1ps
module tb;
    import gatl_pkg::*;
    localparam int SEC = 20;
    typedef struct packed {
        gatl_al_sel_t al; gatl_ref_t rf; logic [3:0] q; logic near; logic pres; logic exp;
    } gatl_arow_t;
    typedef struct packed {gatl_fmt_t f; logic [15:0] d; logic [15:0] e;} gatl_crow_t;
    localparam gatl_arow_t AROWS [10] = '{
        '{GATL_AL_NONE, GATL_REF_SAT, 4'h0, 1'b1, 1'b0, 1'b0},
        '{GATL_AL_SIGWARN, GATL_REF_SAT, 4'h3, 1'b0, 1'b1, 1'b1},
        '{GATL_AL_SIGWARN, GATL_REF_SAT, 4'h8, 1'b0, 1'b1, 1'b0},
        '{GATL_AL_SIGWARN, GATL_REF_GENLOCK, 4'h3, 1'b0, 1'b1, 1'b0},
        '{GATL_AL_NEARGL, GATL_REF_GENLOCK, 4'h8, 1'b1, 1'b1, 1'b1},
        '{GATL_AL_NEARGL, GATL_REF_SAT, 4'h8, 1'b1, 1'b1, 1'b0},
        '{GATL_AL_NOGL, GATL_REF_GENLOCK, 4'h8, 1'b0, 1'b0, 1'b1},
        '{GATL_AL_NOGL, GATL_REF_GENLOCK, 4'h8, 1'b0, 1'b1, 1'b0},
        '{GATL_AL_NOGL, GATL_REF_INT, 4'h8, 1'b0, 1'b0, 1'b0},
        '{GATL_AL_SIGWARN, GATL_REF_INT, 4'h0, 1'b0, 1'b1, 1'b0}};
    localparam gatl_crow_t CROWS [5] = '{
        '{GATL_FMT_24, 16'h7530, 16'h515E}, '{GATL_FMT_2398, 16'h8AD0, 16'hAE8E},
        '{GATL_FMT_25, 16'h4E21, 16'h4E20}, '{GATL_FMT_30, 16'hBE21, 16'hBEE2},
        '{GATL_FMT_30DF, 16'h4158, 16'h4128}};
    logic               clk_i, rst_b_i, vitc_mode_i, frame_tick_i, tc_valid_i, reading_tick_i;
    logic [3:0]         sats_used_i, signal_quality_level_i, warn_level_i, snap;
    logic               rst_prog_time_o, pos_store_o, reacq_busy_o, jam_sync_o, load_tod_o;
    logic               alarm_output_o, alarm_output_oe_o, sat_below_thr_i, genlock_unlock_i;
    logic               alarm_time_hit_i, tune_near_end_i, genlock_present_i, diag_clr_i;
    logic               gl_vld_i, ltcp_vld_i, ltcn_vld_i;
    wire logic          trigger_input_i, alarm_pin;
    logic [4:0]         lol_hours_i;
    logic [5:0]         lol_mins_i, lol_secs_i;
    logic [11:0]        gl_smp_i, ltcp_smp_i, ltcn_smp_i;
    logic signed [15:0] ltc_delay_us_i, ltc_delay_us_o;
    gatl_in_sel_t       in_sel_i;
    gatl_al_sel_t       al_sel_i;
    gatl_ref_t          ref_sel_i;
    gatl_lock_t         lock_state_i, lock_state_o;
    gatl_fmt_t          ltc_fmt_i;
    gatl_bus_t          gl_bus_o;
    gatl_mm_t           gl_mm_o, ltcp_mm_o, ltcn_mm_o;
    int                 n_fail, total_checks, cyc, n_rpt, n_pos, n_jam, n_tod, n_hi;
    ////////////////////////////////////////////////////////////
    gatl_top #(.ONE_SEC_CYC(SEC), .W(12)) uut (.clk_i, .rst_b_i, .trigger_input_i, .in_sel_i,
        .vitc_mode_i, .frame_tick_i, .tc_valid_i, .reading_tick_i, .sats_used_i,
        .rst_prog_time_o, .pos_store_o, .reacq_busy_o, .jam_sync_o, .load_tod_o, .al_sel_i,
        .ref_sel_i, .signal_quality_level_i, .warn_level_i, .sat_below_thr_i,
        .genlock_unlock_i, .lol_hours_i, .lol_mins_i, .lol_secs_i, .alarm_time_hit_i,
        .tune_near_end_i, .genlock_present_i, .alarm_output_o, .alarm_output_oe_o,
        .lock_state_i, .lock_state_o, .ltc_fmt_i, .ltc_delay_us_i, .ltc_delay_us_o,
        .diag_clr_i, .gl_vld_i, .gl_smp_i, .ltcp_vld_i, .ltcp_smp_i, .ltcn_vld_i,
        .ltcn_smp_i, .gl_bus_o, .gl_mm_o, .ltcp_mm_o, .ltcn_mm_o);
    gatl_ext_model ext (.alarm_output_i(alarm_output_o), .alarm_output_oe_i(alarm_output_oe_o),
        .trigger_input_o(trigger_input_i), .alarm_pin_o(alarm_pin));
    ////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        n_rpt += int'(rst_prog_time_o === 1'b1);
        n_pos += int'(pos_store_o === 1'b1);
        n_jam += int'(jam_sync_o === 1'b1);
        n_tod += int'(load_tod_o === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic tick();
        @(posedge clk_i);
        #2;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // snapshot taken three edges after the fall; held low long to catch repeats
    task automatic trig(input gatl_in_sel_t s);
        in_sel_i = s;
        {n_rpt, n_pos, n_jam, n_tod} = '0;
        ext.drive(1'b1);
        repeat (3) tick();
        snap = {rst_prog_time_o, jam_sync_o, load_tod_o, reacq_busy_o};
        repeat (8) tick();
        ext.drive(1'b0);
        repeat (4) tick();
    endtask
    task automatic frames(input int n, input logic ok);
        tc_valid_i = ok;
        repeat (n) begin
            frame_tick_i = 1'b1;
            tick();
            frame_tick_i = 1'b0;
            tick();
        end
    endtask
    task automatic readings(input int n, input logic [3:0] s);
        sats_used_i = s;
        repeat (n) begin
            reading_tick_i = 1'b1;
            tick();
            reading_tick_i = 1'b0;
            tick();
        end
    endtask
    task automatic sample(input logic [11:0] v);
        {gl_vld_i, ltcp_vld_i, ltcn_vld_i} = 3'b111;
        {gl_smp_i, ltcp_smp_i, ltcn_smp_i} = {v, v, ~v};
        tick();
        {gl_vld_i, ltcp_vld_i, ltcn_vld_i} = 3'b000;
    endtask
    task automatic reset_check();
        rst_b_i = 1'b0;
        repeat (10) @(posedge clk_i);
        check({reacq_busy_o, alarm_output_oe_o, rst_prog_time_o, jam_sync_o}, 0, "reset outs");
        check(lock_state_o, GATL_LOCK_BOOT, "reset lock");
        #2 rst_b_i = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {n_fail, total_checks, cyc, n_rpt, n_pos, n_jam, n_tod} = '0;
        {vitc_mode_i, frame_tick_i, tc_valid_i, reading_tick_i, alarm_time_hit_i} = '0;
        {sat_below_thr_i, genlock_unlock_i, tune_near_end_i, diag_clr_i} = '0;
        {gl_vld_i, ltcp_vld_i, ltcn_vld_i, gl_smp_i, ltcp_smp_i, ltcn_smp_i} = '0;
        {lol_hours_i, lol_mins_i, sats_used_i, signal_quality_level_i} = '0;
        genlock_present_i = 1'b1;
        lol_secs_i = 6'h02;
        warn_level_i = 4'h8;
        ltc_delay_us_i = '0;
        in_sel_i = GATL_IN_NONE;
        al_sel_i = GATL_AL_NONE;
        ref_sel_i = GATL_REF_SAT;
        lock_state_i = GATL_LOCK_BOOT;
        ltc_fmt_i = GATL_FMT_24;
        reset_check();
        foreach (AROWS[i]) begin
            al_sel_i = AROWS[i].al;
            ref_sel_i = AROWS[i].rf;
            signal_quality_level_i = AROWS[i].q;
            {tune_near_end_i, genlock_present_i} = {AROWS[i].near, AROWS[i].pres};
            repeat (2) tick();
            check(alarm_output_oe_o, AROWS[i].exp, "alarm enable");
            check(alarm_pin, !AROWS[i].exp, "alarm pin");
        end
        foreach (CROWS[i]) begin
            ltc_fmt_i = CROWS[i].f;
            ltc_delay_us_i = CROWS[i].d;
            repeat (2) tick();
            check($unsigned(ltc_delay_us_o), CROWS[i].e, "delay clamp");
        end
        for (int k = 0; k < 3; k++) begin
            lock_state_i = gatl_lock_t'(k);
            repeat (2) tick();
            check(lock_state_o, k[1:0], "lock state");
        end
        al_sel_i = GATL_AL_NONE;
        genlock_present_i = 1'b1;
        trig(GATL_IN_RST_PT);
        check(snap, 4'b1000, "time reset pulse");
        check(n_rpt, 1, "one action per fall");
        trig(GATL_IN_NONE);
        check(n_rpt + n_jam + n_tod + n_pos, 0, "none ignored");
        frames(99, 1'b1);
        trig(GATL_IN_JAM);
        check(n_jam, 0, "jam refused at 99");
        frames(1, 1'b1);
        trig(GATL_IN_JAM);
        check(snap, 4'b0100, "jam sat mode");
        vitc_mode_i = 1'b1;
        trig(GATL_IN_JAM);
        check(snap, 4'b0110, "jam video mode");
        frames(1, 1'b0);
        frames(60, 1'b1);
        trig(GATL_IN_JAM);
        check(n_jam + n_tod, 0, "jam after broken run");
        trig(GATL_IN_REACQ);
        check(snap, 4'b0001, "reacquire busy");
        readings(59, 4'h4);
        readings(5, 4'h3);
        check({reacq_busy_o, 4'(n_pos)}, 5'h10, "store too early");
        readings(1, 4'h4);
        check({reacq_busy_o, 4'(n_pos)}, 5'h01, "store at 60");
        al_sel_i = GATL_AL_TIME;
        ref_sel_i = GATL_REF_INT;
        sat_below_thr_i = 1'b1;
        alarm_time_hit_i = 1'b1;
        tick();
        alarm_time_hit_i = 1'b0;
        n_hi = 0;
        repeat (3 * SEC) begin
            n_hi += int'(alarm_output_oe_o === 1'b1);
            tick();
        end
        check(n_hi, SEC, "alarm time length");
        al_sel_i = GATL_AL_LOL;
        ref_sel_i = GATL_REF_SAT;
        sat_below_thr_i = 1'b0;
        repeat (2) tick();
        sat_below_thr_i = 1'b1;
        repeat (15) tick();
        check(alarm_output_oe_o, 0, "lol before delay");
        repeat (3 * SEC) tick();
        check(alarm_output_oe_o, 1, "lol after delay");
        sat_below_thr_i = 1'b0;
        repeat (2) tick();
        check(alarm_output_oe_o, 0, "lol cleared");
        ref_sel_i = GATL_REF_GENLOCK;
        genlock_unlock_i = 1'b1;
        repeat (3 * SEC) tick();
        check(alarm_output_oe_o, 1, "genlock lol");
        ref_sel_i = GATL_REF_INT;
        repeat (2) tick();
        check(alarm_output_oe_o, 0, "lol under internal");
        genlock_unlock_i = 1'b0;
        al_sel_i = GATL_AL_NONE;
        diag_clr_i = 1'b1;
        tick();
        diag_clr_i = 1'b0;
        sample(12'h405);
        sample(12'hC00);
        sample(12'h4F0);
        tick();
        check(gl_mm_o, 24'h405_C00, "gl min max");
        check(ltcp_mm_o, 24'h405_C00, "pos min max");
        check(ltcn_mm_o, 24'h3FF_BFA, "neg min max");
        check(gl_bus_o.stuck_hi, 12'h400, "stuck high");
        check(gl_bus_o.stuck_lo, 12'h30A, "stuck low");
        check(gl_bus_o.shorted, 12'h170, "shorted");
        check(alarm_output_oe_o, 0, "diag leaves alarm");
        reset_check();
        stop_test();
    end
endmodule

// >>> verilog/gatl_busmon.sv
// stuck and shorted line watch for the genlock adc bus
`timescale 1ns/1ps
`include "gatl_cfg.svh"
module gatl_busmon #(
    parameter int W = `GATL_ADC_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          clr_i,
    input  wire logic          vld_i,
    input  wire logic [W-1:0]  smp_i,
    output gatl_pkg::gatl_bus_t bus_o
);
    import gatl_pkg::*;
    logic [W-1:0] saw1;
    logic [W-1:0] saw0;
    logic [W-1:0] differ;
    logic [W-1:0] next_diff;
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pair
            // last line has no upper neighbour
            if (g < W-1) begin : g_n
                assign next_diff[g] = smp_i[g] ^ smp_i[g+1];
            end else begin : g_e
                assign next_diff[g] = 1'b0;
            end
        end
    endgenerate
    // a sample in the clearing cycle is kept, not lost
    wire [W-1:0] old1 = clr_i ? '0 : saw1;
    wire [W-1:0] old0 = clr_i ? '0 : saw0;
    wire [W-1:0] oldd = clr_i ? '0 : differ;
    wire [W-1:0] vm   = {W{vld_i}};
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            saw1   <= '0;
            saw0   <= '0;
            differ <= '0;
        end else begin
            saw1   <= old1 | (smp_i & vm);
            saw0   <= old0 | (~smp_i & vm);
            differ <= oldd | (next_diff & vm);
        end
    end
    wire [W-1:0] any_seen = saw1 | saw0;
    assign bus_o.stuck_hi = 12'(saw1 & ~saw0);
    assign bus_o.stuck_lo = 12'(saw0 & ~saw1);
    // once any sample is seen, a pair never seen differing is flagged shorted
    assign bus_o.shorted  = 12'(any_seen & ~differ & {1'b0, {(W-1){1'b1}}});
endmodule

// >>> verilog/gatl_cfg.svh
// constants for the trigger and alarm block
`ifndef GATL_CFG_SVH
`define GATL_CFG_SVH
`define GATL_CLK_HZ          20000000
`define GATL_ONE_SEC_CYC     (`GATL_CLK_HZ)
`define GATL_POS_READINGS    60
`define GATL_POS_SATS        4
`define GATL_JAM_FRAMES      100
`define GATL_ADC_W           12
`define GATL_RAW_W           12
`define GATL_DLY_W           17
`define GATL_SEC_PER_HR      3600
`define GATL_SEC_PER_MIN     60
`define GATL_LIM_US_24       20830
`define GATL_LIM_US_2398     20850
`define GATL_LIM_US_25       20000
`define GATL_LIM_US_30       16670
`define GATL_LIM_US_30DF     16680
`endif

// >>> verilog/gatl_minmax.sv
// running minimum and maximum of one sample stream
`timescale 1ns/1ps
`include "gatl_cfg.svh"
module gatl_minmax #(
    parameter int W = `GATL_ADC_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              clr_i,
    input  wire logic              vld_i,
    input  wire logic [W-1:0]      smp_i,
    output gatl_pkg::gatl_mm_t     mm_o
);
    import gatl_pkg::*;
    logic [W-1:0] lo;
    logic [W-1:0] hi;
    logic         seen;
    // a sample in the clearing cycle starts the new record
    wire          fresh   = clr_i || !seen;
    wire          take_lo = vld_i && (fresh || smp_i < lo);
    wire          take_hi = vld_i && (fresh || smp_i > hi);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lo   <= '0;
            hi   <= '0;
            seen <= 1'b0;
        end else begin
            if (take_lo) lo <= smp_i;
            if (take_hi) hi <= smp_i;
            seen <= vld_i || (seen && !clr_i);
        end
    end
    assign mm_o.min = 12'(lo);
    assign mm_o.max = 12'(hi);
endmodule

// >>> verilog/gatl_pkg.sv
// types for the trigger and alarm block
package gatl_pkg;
    typedef enum logic [1:0] {GATL_IN_NONE, GATL_IN_RST_PT, GATL_IN_REACQ, GATL_IN_JAM} gatl_in_sel_t;
    typedef enum logic [2:0] {GATL_AL_NONE, GATL_AL_SIGWARN, GATL_AL_LOL, GATL_AL_TIME,
                              GATL_AL_NEARGL, GATL_AL_NOGL} gatl_al_sel_t;
    typedef enum logic [1:0] {GATL_REF_SAT, GATL_REF_GENLOCK, GATL_REF_INT} gatl_ref_t;
    typedef enum logic [1:0] {GATL_LOCK_BOOT, GATL_LOCK_COARSE, GATL_LOCK_FINE} gatl_lock_t;
    typedef enum logic [2:0] {GATL_FMT_2398, GATL_FMT_24, GATL_FMT_25, GATL_FMT_30,
                              GATL_FMT_30DF} gatl_fmt_t;
    typedef struct packed {
        logic [11:0] min;
        logic [11:0] max;
    } gatl_mm_t;
    typedef struct packed {
        logic [11:0] stuck_hi;
        logic [11:0] stuck_lo;
        logic [11:0] shorted;
    } gatl_bus_t;
endpackage

// >>> verilog/gatl_top.sv
// trigger input actions, alarm output selection and diagnostics capture
`timescale 1ns/1ps
`include "gatl_cfg.svh"
module gatl_top #(
    parameter int ONE_SEC_CYC = `GATL_ONE_SEC_CYC,
    parameter int W           = `GATL_ADC_W
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  trigger_input_i,
    input  gatl_pkg::gatl_in_sel_t     in_sel_i,
    input  wire logic                  vitc_mode_i,
    input  wire logic                  frame_tick_i,
    input  wire logic                  tc_valid_i,
    input  wire logic                  reading_tick_i,
    input  wire logic [3:0]            sats_used_i,
    output logic                       rst_prog_time_o,
    output logic                       pos_store_o,
    output logic                       reacq_busy_o,
    output logic                       jam_sync_o,
    output logic                       load_tod_o,
    input  gatl_pkg::gatl_al_sel_t     al_sel_i,
    input  gatl_pkg::gatl_ref_t        ref_sel_i,
    input  wire logic [3:0]            signal_quality_level_i,
    input  wire logic [3:0]            warn_level_i,
    input  wire logic                  sat_below_thr_i,
    input  wire logic                  genlock_unlock_i,
    input  wire logic [4:0]            lol_hours_i,
    input  wire logic [5:0]            lol_mins_i,
    input  wire logic [5:0]            lol_secs_i,
    input  wire logic                  alarm_time_hit_i,
    input  wire logic                  tune_near_end_i,
    input  wire logic                  genlock_present_i,
    output logic                       alarm_output_o,
    output logic                       alarm_output_oe_o,
    input  gatl_pkg::gatl_lock_t       lock_state_i,
    output gatl_pkg::gatl_lock_t       lock_state_o,
    input  gatl_pkg::gatl_fmt_t        ltc_fmt_i,
    input  wire logic signed [15:0]    ltc_delay_us_i,
    output logic signed [15:0]         ltc_delay_us_o,
    input  wire logic                  diag_clr_i,
    input  wire logic                  gl_vld_i,
    input  wire logic [W-1:0]          gl_smp_i,
    input  wire logic                  ltcp_vld_i,
    input  wire logic [W-1:0]          ltcp_smp_i,
    input  wire logic                  ltcn_vld_i,
    input  wire logic [W-1:0]          ltcn_smp_i,
    output gatl_pkg::gatl_bus_t        gl_bus_o,
    output gatl_pkg::gatl_mm_t         gl_mm_o,
    output gatl_pkg::gatl_mm_t         ltcp_mm_o,
    output gatl_pkg::gatl_mm_t         ltcn_mm_o
);
    import gatl_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // trigger input
    logic trig_s1;
    logic trig_s2;
    logic trig_d;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trig_s1 <= 1'b1;
            trig_s2 <= 1'b1;
            trig_d  <= 1'b1;
        end else begin
            trig_s1 <= trigger_input_i;
            trig_s2 <= trig_s1;
            trig_d  <= trig_s2;
        end
    end
    wire trig_fall = trig_d && !trig_s2;
    wire go_rst    = trig_fall && (in_sel_i == GATL_IN_RST_PT);
    wire go_reacq  = trig_fall && (in_sel_i == GATL_IN_REACQ);
    wire go_jam    = trig_fall && (in_sel_i == GATL_IN_JAM);
    ////////////////////////////////////////////////////////////////////////////
    // timecode validity run
    logic [6:0] frame_run;
    wire        tc_ok = (frame_run >= 7'(`GATL_JAM_FRAMES));
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_run <= '0;
        end else if (!tc_valid_i) begin
            frame_run <= '0;
        end else if (frame_tick_i && !tc_ok) begin
            frame_run <= frame_run + 7'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // reacquire position
    logic [5:0] read_cnt;
    wire        good_read = reading_tick_i && (sats_used_i >= 4'(`GATL_POS_SATS));
    wire        read_done = good_read && (read_cnt == 6'(`GATL_POS_READINGS - 1));
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reacq_busy_o <= 1'b0;
            read_cnt     <= '0;
            pos_store_o  <= 1'b0;
        end else begin
            pos_store_o <= reacq_busy_o && read_done;
            if (go_reacq) begin
                reacq_busy_o <= 1'b1;
                read_cnt     <= '0;
            end else if (reacq_busy_o && read_done) begin
                reacq_busy_o <= 1'b0;
            end else if (reacq_busy_o && good_read) begin
                read_cnt <= read_cnt + 6'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // action pulses
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_prog_time_o <= 1'b0;
            jam_sync_o      <= 1'b0;
            load_tod_o      <= 1'b0;
        end else begin
            rst_prog_time_o <= go_rst;
            jam_sync_o      <= go_jam && tc_ok;
            load_tod_o      <= go_jam && tc_ok && vitc_mode_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // loss of lock delay
    wire [`GATL_DLY_W-1:0] lol_target = 17'(lol_hours_i) * 17'(`GATL_SEC_PER_HR)
                                      + 17'(lol_mins_i) * 17'(`GATL_SEC_PER_MIN)
                                      + 17'(lol_secs_i);
    logic [31:0]             sec_div;
    logic [`GATL_DLY_W-1:0]  lol_secs;
    wire                     sec_tick = (sec_div == 32'(ONE_SEC_CYC - 1));
    wire                     lol_cond = sat_below_thr_i || genlock_unlock_i;
    wire                     lol_ripe = lol_cond && (lol_secs >= lol_target);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sec_div  <= '0;
            lol_secs <= '0;
        end else begin
            sec_div <= sec_tick ? 32'h0000_0000 : sec_div + 32'h0000_0001;
            if (!lol_cond) begin
                lol_secs <= '0;
            end else if (sec_tick && !lol_ripe) begin
                lol_secs <= lol_secs + 17'h0_0001;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // alarm time one second hold
    logic [31:0] at_cnt;
    wire         at_on = (at_cnt != 32'h0000_0000);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            at_cnt <= '0;
        end else if (alarm_time_hit_i) begin
            at_cnt <= 32'(ONE_SEC_CYC);
        end else if (at_on) begin
            at_cnt <= at_cnt - 32'h0000_0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // alarm selection and reference gating
    wire is_sat  = (ref_sel_i == GATL_REF_SAT);
    wire is_gl   = (ref_sel_i == GATL_REF_GENLOCK);
    // with the satellite reference, quality below warning level holds the pin low, release at the level
    wire sw_act  = is_sat && (signal_quality_level_i < warn_level_i);
    wire lol_act = (is_sat || is_gl) && lol_ripe;
    wire ngl_act = is_gl && tune_near_end_i;
    wire nog_act = is_gl && !genlock_present_i;
    logic al_act;
    always_comb begin
        unique case (al_sel_i)
            GATL_AL_NONE:    al_act = 1'b0;
            GATL_AL_SIGWARN: al_act = sw_act;
            GATL_AL_LOL:     al_act = lol_act;
            GATL_AL_TIME:    al_act = at_on;
            GATL_AL_NEARGL:  al_act = ngl_act;
            GATL_AL_NOGL:    al_act = nog_act;
            default:         al_act = 1'b0;
        endcase
    end
    logic al_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            al_q <= 1'b0;
        end else begin
            al_q <= al_act;
        end
    end
    assign alarm_output_o    = 1'b0;
    assign alarm_output_oe_o = al_q;
    ////////////////////////////////////////////////////////////////////////////
    // timecode delay clamp
    logic signed [15:0] lim;
    always_comb begin
        unique case (ltc_fmt_i)
            GATL_FMT_2398: lim = 16'(`GATL_LIM_US_2398);
            GATL_FMT_24:   lim = 16'(`GATL_LIM_US_24);
            GATL_FMT_25:   lim = 16'(`GATL_LIM_US_25);
            GATL_FMT_30:   lim = 16'(`GATL_LIM_US_30);
            GATL_FMT_30DF: lim = 16'(`GATL_LIM_US_30DF);
            default:       lim = 16'(`GATL_LIM_US_30);
        endcase
    end
    wire signed [15:0] nlim = -lim;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ltc_delay_us_o <= '0;
        end else if (ltc_delay_us_i > lim) begin
            ltc_delay_us_o <= lim;
        end else if (ltc_delay_us_i < nlim) begin
            ltc_delay_us_o <= nlim;
        end else begin
            ltc_delay_us_o <= ltc_delay_us_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // diagnostics, outputs only, nothing above reads them
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_state_o <= GATL_LOCK_BOOT;
        end else begin
            lock_state_o <= lock_state_i;
        end
    end
    gatl_busmon #(.W(W)) u_bus (
        .clk_i  (clk_i),
        .rst_b_i(rst_b_i),
        .clr_i  (diag_clr_i),
        .vld_i  (gl_vld_i),
        .smp_i  (gl_smp_i),
        .bus_o  (gl_bus_o)
    );
    gatl_minmax #(.W(W)) u_gl (
        .clk_i  (clk_i),
        .rst_b_i(rst_b_i),
        .clr_i  (diag_clr_i),
        .vld_i  (gl_vld_i),
        .smp_i  (gl_smp_i),
        .mm_o   (gl_mm_o)
    );
    gatl_minmax #(.W(W)) u_lp (
        .clk_i  (clk_i),
        .rst_b_i(rst_b_i),
        .clr_i  (diag_clr_i),
        .vld_i  (ltcp_vld_i),
        .smp_i  (ltcp_smp_i),
        .mm_o   (ltcp_mm_o)
    );
    gatl_minmax #(.W(W)) u_ln (
        .clk_i  (clk_i),
        .rst_b_i(rst_b_i),
        .clr_i  (diag_clr_i),
        .vld_i  (ltcn_vld_i),
        .smp_i  (ltcn_smp_i),
        .mm_o   (ltcn_mm_o)
    );
    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_fall;
        $fell(trig_s2) ##0 (in_sel_i == GATL_IN_RST_PT);
    endsequence
    a_trig_rst_once: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_fall |=> rst_prog_time_o ##1 !rst_prog_time_o) else $error("reset pulse wrong");
    a_jam_needs_run: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        jam_sync_o |-> $past(frame_run) >= 7'(`GATL_JAM_FRAMES))
        else $error("jam without valid run");
    a_load_needs_vitc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        load_tod_o |-> jam_sync_o && $past(vitc_mode_i)) else $error("bad time load");
    a_none_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ($past(al_sel_i) == GATL_AL_NONE) |-> !alarm_output_oe_o) else $error("none drove pin");
    a_int_ref_time: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ($past(ref_sel_i) == GATL_REF_INT && $past(al_sel_i) != GATL_AL_TIME)
        |-> !alarm_output_oe_o) else $error("internal ref alarm");
    a_gl_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ($past(al_sel_i) == GATL_AL_NOGL && $past(ref_sel_i) != GATL_REF_GENLOCK)
        |-> !alarm_output_oe_o) else $error("genlock alarm ungated");
    a_time_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        alarm_time_hit_i |=> at_on [*8]) else $error("alarm time not held");
    a_pos_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        pos_store_o |-> $past(read_cnt) == 6'(`GATL_POS_READINGS - 1) && !reacq_busy_o)
        else $error("early store");
    a_clamp: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ltc_delay_us_o <= $past(lim) && ltc_delay_us_o >= $past(nlim))
        else $error("delay range");
endmodule
